// >>> pkg/imcd_pkg.sv
// package for the interrupt mask and clock divider block
package imcd_pkg;
	localparam int NUM_SRC = 6;
	// register byte addresses
	localparam logic [7:0] ADDR_MASK = 8'hfb;
	localparam logic [7:0] ADDR_REQ = 8'hfa;
	localparam logic [7:0] ADDR_RECOV = 8'h0b;
	localparam logic [7:0] ADDR_ISTAT = 8'h10;
	localparam logic [7:0] ADDR_IEN = 8'h14;
	// field positions
	localparam int MASTER_BIT = 7;
	localparam int RSVD_BIT = 6;
	localparam int PRESCALE_BIT = 0;
	localparam int DELAY_BIT = 5;
	localparam int ISTAT_SVC = 0;
	localparam int ISTAT_WAKE = 1;
	// reset values
	localparam logic MASTER_RST = 1'b0;
	localparam logic [5:0] SRC_EN_RST = 6'h00;
	localparam logic PRESCALE_RST = 1'b0;
	localparam logic DELAY_RST = 1'b1;
	localparam logic [5:0] REQ_RST = 6'h00;
	localparam logic [1:0] IRQ_RST = 2'h0;
	// timing
	localparam int CLK_MHZ = 50;
	localparam int POWER_ON_DELAY_US = 5000;
	localparam int POWER_ON_DELAY_CYC = POWER_ON_DELAY_US * CLK_MHZ;
	localparam int DIV_BASE = 2;
	localparam int DIV_PRESCALE = 16;
endpackage : imcd_pkg

// >>> rtl/imcd_top.sv
// interrupt mask stage with its clock divider and wishbone slave
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ns
// What this block does
// - bits 5 to 0 of the mask register enable one source each, one meaning enabled.
// - bit 7 is the master enable; zero blocks all, one lets each source follow its own bit.
// - reset clears the master enable and the source bits.
// - system and timer clock ticks come from the oscillator divided by two.
// - recovery register bit 0 adds a divide by sixteen after the divide by two.
// - power-on reset and stop recovery both clear the prescaler selection.
// - the cpu runs on the system tick, and while halted the interrupt logic runs on the timer tick.
// - recovery register bit 5 selects a power-on length start delay, else start at once.
// - a latched request is serviced only when enabled, else it stays as a flag.
// - servicing a request clears its pending bit.
module imcd_top #(
	parameter int NSRC = imcd_pkg::NUM_SRC,
	parameter int DELAY_CYC = imcd_pkg::POWER_ON_DELAY_CYC
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [5:0] srcSet,
	input wire logic unmaskAll,
	input wire logic maskAll,
	input wire logic halted,
	input wire logic stopWake,
	input wire logic [5:0] svcAck,
	output logic [5:0] intPresent,
	output logic sysTick,
	output logic timerTick,
	output logic cpuRun,
	output logic irq
);
	import imcd_pkg::*;

	logic rstSync1, rstSync2;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rstSync1 <= 1'b0;
			rstSync2 <= 1'b0;
		end else begin
			rstSync1 <= 1'b1;
			rstSync2 <= rstSync1;
		end
	end
	wire rstN = rstSync2;

	// bus decode
	wire wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wbWr = wbReq && wb_we_i && wb_sel_i[0];
	wire selMask = wb_adr_i == ADDR_MASK;
	wire selReq = wb_adr_i == ADDR_REQ;
	wire selRecov = wb_adr_i == ADDR_RECOV;
	wire selIstat = wb_adr_i == ADDR_ISTAT;
	wire selIen = wb_adr_i == ADDR_IEN;
	wire [7:0] wd = wb_dat_i[7:0];

	logic masterEn_q, masterEn_d;
	logic [5:0] srcEn_q, srcEn_d;
	logic [5:0] req_q, req_d;
	logic prescale_q, prescale_d;
	logic delaySel_q, delaySel_d;
	logic [1:0] istat_q, istat_d;
	logic [1:0] ien_q, ien_d;
	logic ack_q;

	// master bit moves by instruction or by bus write; instructions win
	always_comb begin
		masterEn_d = masterEn_q;
		if (wbWr && selMask)
			masterEn_d = wd[MASTER_BIT];
		if (unmaskAll)
			masterEn_d = 1'b1;
		if (maskAll)
			masterEn_d = 1'b0;
	end
	assign srcEn_d = (wbWr && selMask) ? wd[5:0] : srcEn_q;

	// service only what is presented; set beats both clears
	wire [5:0] svcHit = svcAck & intPresent;
	wire [5:0] reqSwSet = (wbWr && selReq) ? wd[5:0] : 6'h00;
	wire [5:0] reqSwClr = (wbWr && selReq) ? ~wd[5:0] : 6'h00;
	assign req_d = (req_q & ~reqSwClr & ~svcHit) | srcSet | reqSwSet;

	// stop recovery clears the prescaler as reset does
	always_comb begin
		prescale_d = prescale_q;
		delaySel_d = delaySel_q;
		if (wbWr && selRecov) begin
			prescale_d = wd[PRESCALE_BIT];
			delaySel_d = wd[DELAY_BIT];
		end
		if (stopWake)
			prescale_d = PRESCALE_RST;
	end

	wire svcEvt = |svcHit;
	logic wakeDone;
	wire [1:0] evt = {wakeDone, svcEvt};
	wire [1:0] istClr = (wbWr && selIstat) ? wd[1:0] : 2'h0;
	assign istat_d = (istat_q & ~istClr) | evt;
	assign ien_d = (wbWr && selIen) ? wd[1:0] : ien_q;

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			masterEn_q <= MASTER_RST;
			srcEn_q <= SRC_EN_RST;
			req_q <= REQ_RST;
			prescale_q <= PRESCALE_RST;
			delaySel_q <= DELAY_RST;
			istat_q <= IRQ_RST;
			ien_q <= IRQ_RST;
			ack_q <= 1'b0;
		end else begin
			masterEn_q <= masterEn_d;
			srcEn_q <= srcEn_d;
			req_q <= req_d;
			prescale_q <= prescale_d;
			delaySel_q <= delaySel_d;
			istat_q <= istat_d;
			ien_q <= ien_d;
			ack_q <= wbReq;
		end
	end

	assign intPresent = req_q & srcEn_q & {6{masterEn_q}};
	assign irq = |(istat_q & ien_q);
	assign wb_ack_o = ack_q;

	// read data registered at request; bit 6 reads zero
	logic [31:0] rdat_q;
	wire [7:0] rdMask = {masterEn_q, 1'b0, srcEn_q};
	wire [7:0] rdRecov = {2'b00, delaySel_q, 4'h0, prescale_q};
	wire [7:0] rdByte = selMask ? rdMask : selReq ? {2'b00, req_q} : selRecov ? rdRecov :
		selIstat ? {6'h00, istat_q} : selIen ? {6'h00, ien_q} : 8'h00;
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN)
			rdat_q <= 32'h00000000;
		else if (wbReq)
			rdat_q <= {24'h000000, rdByte};
	end
	assign wb_dat_o = rdat_q;

	// divider: /2 always, then optional /16
	logic div2_q;
	logic [3:0] div16_q;
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			div2_q <= 1'b0;
			div16_q <= 4'h0;
		end else begin
			div2_q <= ~div2_q;
			if (div2_q)
				div16_q <= div16_q + 4'h1;
		end
	end
	wire baseTick = div2_q;
	wire preTick = div2_q && (div16_q == 4'hf);
	wire tick = prescale_q ? preTick : baseTick;
	assign timerTick = tick && halted;
	assign sysTick = tick && !halted && cpuRun;

	// stop recovery start delay
	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_WAIT = 2'b10
	} imcd_state_t;
	imcd_state_t state_q, state_d;
	logic [31:0] dcnt_q, dcnt_d;
	always_comb begin
		state_d = state_q;
		dcnt_d = dcnt_q;
		wakeDone = 1'b0;
		case (state_q)
			ST_RUN: begin
				if (stopWake && delaySel_q) begin
					state_d = ST_WAIT;
					dcnt_d = 32'(DELAY_CYC - 1);
				end else if (stopWake) begin
					wakeDone = 1'b1;
				end
			end
			ST_WAIT: begin
				if (dcnt_q == 32'h00000000) begin
					state_d = ST_RUN;
					wakeDone = 1'b1;
				end else begin
					dcnt_d = dcnt_q - 32'h00000001;
				end
			end
			default: state_d = ST_RUN;
		endcase
	end
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			state_q <= ST_RUN;
			dcnt_q <= 32'h00000000;
		end else begin
			state_q <= state_d;
			dcnt_q <= dcnt_d;
		end
	end
	assign cpuRun = (state_q == ST_RUN);

	// stall length counter, only read by the checks below
	logic [31:0] stallCnt_q;
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN)
			stallCnt_q <= 32'h00000000;
		else if (cpuRun)
			stallCnt_q <= 32'h00000000;
		else
			stallCnt_q <= stallCnt_q + 32'h00000001;
	end

	// mask register
	a_present_gated: assert property (@(posedge sys_clk) disable iff (!rstN)
		(intPresent != 6'h00) |-> masterEn_q)
		else $error("present without master");
	a_mask_write: assert property (@(posedge sys_clk) disable iff (!rstN)
		(wbWr && selMask && !unmaskAll && !maskAll) |=> (srcEn_q == $past(wd[5:0])))
		else $error("source enables not written");
	a_master_off: assert property (@(posedge sys_clk) disable iff (!rstN)
		maskAll |=> !masterEn_q)
		else $error("mask all ignored");
	a_master_on: assert property (@(posedge sys_clk) disable iff (!rstN)
		(unmaskAll && !maskAll) |=> masterEn_q)
		else $error("unmask all ignored");
	a_master_keep: assert property (@(posedge sys_clk) disable iff (!rstN)
		(!unmaskAll && !maskAll && !(wbWr && selMask)) |=> $stable(masterEn_q))
		else $error("master enable moved by itself");
	a_src_keep: assert property (@(posedge sys_clk) disable iff (!rstN)
		!(wbWr && selMask) |=> $stable(srcEn_q))
		else $error("source enables moved by itself");
	// reset lands before the first free edge
	a_reset_master: assert property (@(posedge sys_clk)
		(rstSync1 && !rstN) |=> !masterEn_q)
		else $error("master enable set after reset");
	a_reset_pre: assert property (@(posedge sys_clk)
		(rstSync1 && !rstN) |=> !prescale_q)
		else $error("prescaler set after reset");

	// requests and presentation
	a_svc_clear: assert property (@(posedge sys_clk) disable iff (!rstN)
		(svcHit[0] && !srcSet[0] && !reqSwSet[0]) |=> !req_q[0])
		else $error("serviced bit not cleared");
	a_svc_clr_all: assert property (@(posedge sys_clk) disable iff (!rstN)
		(svcHit != 6'h00 && !(wbWr && selReq)) |=>
		((req_q & $past(svcHit) & ~$past(srcSet)) == 6'h00))
		else $error("serviced bits not cleared");
	a_flag_hold: assert property (@(posedge sys_clk) disable iff (!rstN)
		(req_q[1] && !srcEn_q[1] && !(wbWr && selReq)) |=> req_q[1])
		else $error("disabled request lost");
	a_hidden_keep: assert property (@(posedge sys_clk) disable iff (!rstN)
		!(wbWr && selReq) |=>
		((req_q & $past(req_q) & ~$past(intPresent)) == ($past(req_q) & ~$past(intPresent))))
		else $error("unpresented request lost");
	a_src_set: assert property (@(posedge sys_clk) disable iff (!rstN)
		(srcSet != 6'h00) |=> ((req_q & $past(srcSet)) == $past(srcSet)))
		else $error("source event not latched");
	a_req_write: assert property (@(posedge sys_clk) disable iff (!rstN)
		(wbWr && selReq && srcSet == 6'h00 && svcHit == 6'h00) |=> (req_q == $past(wd[5:0])))
		else $error("request write not taken");
	a_both_set: assert property (@(posedge sys_clk) disable iff (!rstN)
		(intPresent[3] == (req_q[3] && srcEn_q[3] && masterEn_q)))
		else $error("presentation mismatch");
	a_all_present: assert property (@(posedge sys_clk) disable iff (!rstN)
		(masterEn_q && (req_q & srcEn_q) != 6'h00) |-> (intPresent != 6'h00))
		else $error("enabled request not presented");
	a_src_gate: assert property (@(posedge sys_clk) disable iff (!rstN)
		((intPresent & ~srcEn_q) == 6'h00))
		else $error("disabled source presented");
	a_req_gate: assert property (@(posedge sys_clk) disable iff (!rstN)
		((intPresent & ~req_q) == 6'h00))
		else $error("source presented without request");

	// bus side
	a_ack_pulse: assert property (@(posedge sys_clk) disable iff (!rstN)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_next: assert property (@(posedge sys_clk) disable iff (!rstN)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("request not answered");
	a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!rstN)
		(wbReq && selMask) |=> (wb_dat_o[RSVD_BIT] == 1'b0))
		else $error("reserved bit not zero");
	a_read_mask: assert property (@(posedge sys_clk) disable iff (!rstN)
		(wbReq && selMask) |=> (wb_dat_o[7:0] == {$past(masterEn_q), 1'b0, $past(srcEn_q)}))
		else $error("mask read wrong");
	a_read_recov: assert property (@(posedge sys_clk) disable iff (!rstN)
		(wbReq && selRecov) |=> (wb_dat_o[PRESCALE_BIT] == $past(prescale_q)) &&
		(wb_dat_o[DELAY_BIT] == $past(delaySel_q)))
		else $error("recovery read wrong");
	a_read_upper: assert property (@(posedge sys_clk) disable iff (!rstN)
		wbReq |=> (wb_dat_o[31:8] == 24'h000000))
		else $error("upper read bits not zero");
	a_irq_level: assert property (@(posedge sys_clk) disable iff (!rstN)
		(irq == ((istat_q & ien_q) != 2'h0)))
		else $error("irq level wrong");
	a_wake_flag: assert property (@(posedge sys_clk) disable iff (!rstN)
		wakeDone |=> istat_q[ISTAT_WAKE])
		else $error("wake event not flagged");
	a_svc_flag: assert property (@(posedge sys_clk) disable iff (!rstN)
		svcEvt |=> istat_q[ISTAT_SVC])
		else $error("service event not flagged");

	// divider and ticks
	sequence s_pre_quiet8;
		!preTick [*8];
	endsequence
	a_div_toggle: assert property (@(posedge sys_clk) disable iff (!rstN)
		1'b1 |=> $changed(div2_q))
		else $error("divide by two stalled");
	a_base_div: assert property (@(posedge sys_clk) disable iff (!rstN)
		(!prescale_q && tick) |=> !tick)
		else $error("tick not halved");
	a_tick_base: assert property (@(posedge sys_clk) disable iff (!rstN)
		!prescale_q |-> (tick == div2_q))
		else $error("base tick wrong");
	a_tick_pre: assert property (@(posedge sys_clk) disable iff (!rstN)
		prescale_q |-> (tick == preTick))
		else $error("prescaled tick wrong");
	a_pre_div: assert property (@(posedge sys_clk) disable iff (!rstN)
		(prescale_q && preTick && $stable(prescale_q)) |=> (!preTick [*8]))
		else $error("prescale too fast");
	a_pre_period: assert property (@(posedge sys_clk) disable iff (!rstN)
		preTick |-> ##32 preTick)
		else $error("prescale period wrong");
	a_pre_quiet: assert property (@(posedge sys_clk) disable iff (!rstN)
		preTick |=> s_pre_quiet8 ##1 s_pre_quiet8 ##1 s_pre_quiet8 ##1 (!preTick [*7]))
		else $error("extra prescaled tick");
	a_prescale_set: assert property (@(posedge sys_clk) disable iff (!rstN)
		(wbWr && selRecov && !stopWake) |=> (prescale_q == $past(wd[PRESCALE_BIT])))
		else $error("prescale select not written");
	a_prescale_keep: assert property (@(posedge sys_clk) disable iff (!rstN)
		(!(wbWr && selRecov) && !stopWake) |=> $stable(prescale_q))
		else $error("prescale select moved");
	a_wake_clr: assert property (@(posedge sys_clk) disable iff (!rstN)
		(stopWake && !(wbWr && selRecov)) |=> !prescale_q)
		else $error("prescaler kept over recovery");
	a_halt_tick: assert property (@(posedge sys_clk) disable iff (!rstN)
		halted |-> !sysTick)
		else $error("cpu ticks while halted");
	a_timer_idle: assert property (@(posedge sys_clk) disable iff (!rstN)
		!halted |-> !timerTick)
		else $error("timer ticks while running");
	a_timer_halt: assert property (@(posedge sys_clk) disable iff (!rstN)
		(halted && tick) |-> timerTick)
		else $error("timer tick missing in halt");
	a_sys_run: assert property (@(posedge sys_clk) disable iff (!rstN)
		(!halted && cpuRun && tick) |-> sysTick)
		else $error("system tick missing");

	// stop recovery delay
	sequence s_wake_nodelay;
		stopWake && !delaySel_q && (state_q == ST_RUN);
	endsequence
	sequence s_wake_delay;
		stopWake && delaySel_q && (state_q == ST_RUN);
	endsequence
	a_wake_fast: assert property (@(posedge sys_clk) disable iff (!rstN)
		s_wake_nodelay |=> cpuRun)
		else $error("delay without selection");
	a_wake_stall: assert property (@(posedge sys_clk) disable iff (!rstN)
		s_wake_delay |=> !cpuRun && (dcnt_q == 32'(DELAY_CYC - 1)))
		else $error("selected delay not started");
	a_delay_set: assert property (@(posedge sys_clk) disable iff (!rstN)
		(wbWr && selRecov) |=> (delaySel_q == $past(wd[DELAY_BIT])))
		else $error("delay select not written");
	a_stall_quiet: assert property (@(posedge sys_clk) disable iff (!rstN)
		!cpuRun |-> !sysTick)
		else $error("cpu ticks during start delay");
	a_stall_bound: assert property (@(posedge sys_clk) disable iff (!rstN)
		!cpuRun |-> (stallCnt_q < 32'(DELAY_CYC)))
		else $error("start delay too long");
	a_stall_len: assert property (@(posedge sys_clk) disable iff (!rstN)
		(wakeDone && !cpuRun) |=> cpuRun && (stallCnt_q == 32'(DELAY_CYC)))
		else $error("start delay length wrong");
endmodule : imcd_top

// >>> tb/imcd_core_model.sv
// cpu core model issuing global enable, disable and service pulses
`timescale 1ns/1ns
module imcd_core_model (
	input wire logic sys_clk,
	input wire logic doEi,
	input wire logic doDi,
	input wire logic [5:0] doSvc,
	input wire logic [5:0] intPresent,
	output logic unmaskAll,
	output logic maskAll,
	output logic [5:0] svcAck
);
	always_ff @(posedge sys_clk) begin
		unmaskAll <= doEi;
		maskAll <= doDi;
		// a real core only acknowledges what it is shown
		svcAck <= doSvc & intPresent;
	end
endmodule : imcd_core_model

// >>> tb/tb_imcd_top.sv
// self-checking bench for the interrupt mask and clock divider
`timescale 1ns/1ns
module tb_imcd_top;
	import imcd_pkg::*;
	logic sys_clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, halted = 0, stopWake = 0;
	logic ei = 0, di = 0, ack, unmaskAll, maskAll, sysTick, timerTick, cpuRun, irq;
	logic [7:0] adr = 8'h00, q;
	logic [3:0] sel = 4'h1;
	logic [31:0] dati = 32'h0, dato, rs = 32'hd538;
	logic [5:0] srcSet = 6'h00, svc = 6'h00, svcAck, intPresent, en, req;
	int errors = 0, checks_done = 0;
	initial forever #10 sys_clk = ~sys_clk;
	imcd_top #(.DELAY_CYC(20)) u_dut (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dati),
		.wb_dat_o(dato), .wb_ack_o(ack), .srcSet(srcSet), .unmaskAll(unmaskAll),
		.maskAll(maskAll), .halted(halted), .stopWake(stopWake), .svcAck(svcAck),
		.intPresent(intPresent), .sysTick(sysTick), .timerTick(timerTick),
		.cpuRun(cpuRun), .irq(irq));
	imcd_core_model u_core (.sys_clk(sys_clk), .doEi(ei), .doDi(di), .doSvc(svc),
		.intPresent(intPresent), .unmaskAll(unmaskAll), .maskAll(maskAll), .svcAck(svcAck));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction : xs
	task automatic complete_run;
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tk(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : tk
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int t = 0;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dati <= {24'h0, d};
		do begin
			@(posedge sys_clk);
			t++;
		end while (ack !== 1'b1 && t < 50);
		if (t >= 50) begin
			errors++;
			complete_run();
		end
		q = dato[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic ticks(input int es, input int et);
		int s = 0, t = 0;
		repeat (64) begin
			@(negedge sys_clk);
			s += (sysTick === 1'b1);
			t += (timerTick === 1'b1);
		end
		chk(s, es);
		chk(t, et);
	endtask : ticks
	task automatic wake(input int e);
		int c = 0;
		@(posedge sys_clk);
		stopWake <= 1'b1;
		@(posedge sys_clk);
		stopWake <= 1'b0;
		repeat (40) begin
			@(negedge sys_clk);
			c += (cpuRun === 1'b0);
		end
		chk(c, e);
	endtask : wake
	// hang guard, far beyond the whole sequence
	initial begin
		tk(20000);
		errors++;
		complete_run();
	end
	initial begin
		tk(8);
		resetn <= 1'b1;
		tk(3);
		wb(0, ADDR_MASK, 0);
		chk(q[MASTER_BIT], MASTER_RST);
		wb(0, ADDR_RECOV, 0);
		chk(q, 8'h20);
		ticks(32, 0);
		for (int i = 0; i < 6; i++) begin
			rs = xs(rs);
			en = rs[5:0];
			req = rs[13:8];
			@(posedge sys_clk);
			di <= 1'b1;
			srcSet <= 6'h3f;
			@(posedge sys_clk);
			di <= 1'b0;
			srcSet <= 6'h00;
			wb(1, ADDR_MASK, {2'b00, en});
			chk(intPresent, 0);
			wb(0, ADDR_REQ, 0);
			chk(q, 8'h3f);
			wb(1, ADDR_REQ, {2'b00, req});
			ei <= 1'b1;
			@(posedge sys_clk);
			ei <= 1'b0;
			tk(3);
			chk(intPresent, req & en);
			wb(0, ADDR_MASK, 0);
			chk(q, {2'b10, en});
			svc <= 6'h3f;
			@(posedge sys_clk);
			svc <= 6'h00;
			tk(3);
			wb(0, ADDR_REQ, 0);
			chk(q, req & ~en);
		end
		wb(1, ADDR_RECOV, 8'h21);
		ticks(2, 0);
		@(posedge sys_clk);
		halted <= 1'b1;
		ticks(0, 2);
		@(posedge sys_clk);
		halted <= 1'b0;
		wake(20);
		wb(0, ADDR_RECOV, 0);
		chk(q, 8'h20);
		chk(irq, 0);
		wb(1, ADDR_IEN, 8'h02);
		chk(irq, 1);
		wb(1, ADDR_ISTAT, 8'h02);
		chk(irq, 0);
		wb(1, ADDR_RECOV, 8'h00);
		wake(0);
		// byte lane off: the enable write must be ignored
		@(posedge sys_clk);
		sel <= 4'h0;
		wb(1, ADDR_IEN, 8'h00);
		sel <= 4'h1;
		chk(irq, 1);
		wb(0, 8'h77, 0);
		chk(q, 0);
		complete_run();
	end
endmodule : tb_imcd_top
